// ==== stepper_serial_pkg.sv ====
// Purpose: Shared constants and types for the stepper serial register port
// Assumes: 16-bit serial words, two select bits on top, 14 data bits below
// Notes: Reset values are the power-on defaults of the writable registers
package stepper_serial_pkg;

  // Word layout
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 14;
  localparam int SEL_HI = 15;
  localparam int SEL_LO = 14;
  localparam logic [4:0] EDGES_PER_WORD = 5'h10;
  localparam logic [4:0] EDGE_SATURATE = 5'h11;

  // Register select codes
  localparam logic [1:0] SEL_CONFIG_A = 2'h0;
  localparam logic [1:0] SEL_CONFIG_B = 2'h1;
  localparam logic [1:0] SEL_RUN = 2'h2;
  localparam logic [1:0] SEL_TABLE = 2'h3;

  // Power-on defaults of the stored data bits
  localparam logic [13:0] CONFIG_A_RST = 14'h271C;
  localparam logic [13:0] CONFIG_B_RST = 14'h1020;
  localparam logic [13:0] RUN_RST = 14'h0A40;

  // Phase table load word fields
  localparam int PARITY_POS = 6;
  localparam int VALUE_BITS = 6;
  localparam int TABLE_DEPTH = 16;
  localparam int TABLE_IDX_BITS = 4;
  localparam logic [3:0] TABLE_LAST = 4'hF;

  // Diagnostic power-on contents: all ones flags a power-on reset
  localparam logic [6:0] FLAGS_RST = 7'h7F;
  localparam logic [7:0] SHORTS_RST = 8'hFF;

  // Default quadrant of the current profile, entry 0 in the low bits
  localparam logic [95:0] PROFILE_RST = 96'hFFE_F3A_E1C_4D2_C69_1E9_7C5_186;

  // Shared fault flags, upper byte of both diagnostic words below the summary
  typedef struct packed {
    logic temp_warning_hi;
    logic temp_warning_lo;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic stall_flag;
    logic open_load_phase_b;
    logic open_load_phase_a;
  } diag_flags_t;

  // Transfer states
  typedef enum logic {
    XFER_IDLE,
    XFER_SHIFT
  } xfer_state_t;

endpackage

// ==== profile_table_mem.sv ====
// Purpose: Sixteen-entry quadrant store of the phase current profile
// Assumes: Write and read ports on the system clock
// Notes: Contents return to defaults only on power-on reset
`timescale 1ns/1ps
module profile_table_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 6,
  parameter logic [95:0] INIT = stepper_serial_pkg::PROFILE_RST
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  import stepper_serial_pkg::*;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_d;

  localparam int ADDR_BITS = $clog2(DEPTH);

  // Geometry must match the default image
  if (DEPTH * WIDTH != 96) begin : g_bad_geometry
    $error("Profile store geometry does not match its default image");
  end

  // One storage word per entry, loaded by address match
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_q[e] <= INIT[e*WIDTH +: WIDTH];
      end else if (we_i && waddr_i == ADDR_BITS'(e)) begin
        mem_q[e] <= wdata_i;
      end
    end
  end

  // Registered read data
  always_comb begin
    rdata_d = mem_q[raddr_i];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= INIT[WIDTH-1:0];
    end else begin
      rdata_o <= rdata_d;
    end
  end

endmodule

// ==== stepper_serial_port.sv ====
// Purpose: Serial register port of a stepper driver, slave side
// Assumes: Serial clock, strobe, data and reset pin are asynchronous pins
// Notes: Pins are oversampled by MCLK_I; serial clock must stay well below it
// Operation
// R01 - Shift data in on serial clock rise
// R02 - Strobe high: nothing shifts
// R03 - Master sends 16 bits, MSB first
// R04 - Exactly 16 edges: latch, apply, clear diagnostics
// R05 - Wrong edge count: discard, flag transfer error
// R06 - Top two bits select the register
// R07 - Diagnostic word shifts out MSB first
// R08 - Step-angle word only for second configuration
// R09 - Strobe fall: drive summary flag out
// R10 - Poll with clock held high: no error
// R11 - Strobe rise: release serial output
// R12 - Both words share upper eight flags
// R13 - Low bytes: shorts, or step angle
// R14 - Writable registers load defaults at power-on
// R15 - Select 11 loads the current profile
// R16 - Each value serves eight table locations
// R17 - Table index starts at zero, increments
// R18 - After sixteen values, table loads ignored
// R19 - Defaults alone run the motor
// R20 - Each slave has its own strobe
// R21 - Odd parity checked; mismatch still stored
// R22 - Broken sequence returns index to zero
// R23 - Summary flag: shorts, transfer or parity
// R24 - Output data changes after clock fall
// R25 - Unwritten table entries keep old values
`timescale 1ns/1ps
module stepper_serial_port #(
  parameter int TABLE_ENTRIES = 16
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic SCK_I,
  input wire logic SDI_I,
  input wire logic TRANSFER_STROBE_N_I,
  input wire logic RESET_PIN_N_I,
  input wire stepper_serial_pkg::diag_flags_t FAULT_FLAGS_I,
  input wire logic [7:0] SHORT_FAULTS_I,
  input wire logic [5:0] STEP_ANGLE_NUMBER_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  output logic [13:0] DRIVE_CONFIG_A_O,
  output logic [13:0] DRIVE_CONFIG_B_O,
  output logic [13:0] MOTION_RUN_CONTROL_O,
  output logic [5:0] PROFILE_VALUE_O
);
  import stepper_serial_pkg::*;

  // Elaboration check: only the sixteen-entry quadrant is served
  if (TABLE_ENTRIES != TABLE_DEPTH) begin : g_bad_depth
    $error("Profile table depth must be sixteen");
  end


  // Pin synchronisers, first stage read only by second stage
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic sck_s;
  logic sdi_s;
  logic transfer_strobe_n_s;
  logic rstpin_s;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_meta_q <= 4'hC; // Idle levels: reset pin and strobe high
      pin_sync_q <= 4'hC;
    end else begin
      pin_meta_q <= {RESET_PIN_N_I, TRANSFER_STROBE_N_I, SDI_I, SCK_I};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign sck_s = pin_sync_q[0];
  assign sdi_s = pin_sync_q[1];
  assign transfer_strobe_n_s = pin_sync_q[2];
  assign rstpin_s = pin_sync_q[3];

  // Transfer and register state
  xfer_state_t state_q, state_d;
  logic sck_prev_q, sck_prev_d;
  logic transfer_strobe_n_prev_q, transfer_strobe_n_prev_d;
  logic [4:0] edges_q, edges_d;
  logic [15:0] rx_q, rx_d;
  logic sel_b_q, sel_b_d;
  logic sdo_q, sdo_d;
  logic oe_n_q, oe_n_d;
  logic [13:0] cfg_a_q, cfg_a_d;
  logic [13:0] cfg_b_q, cfg_b_d;
  logic [13:0] run_q, run_d;
  logic [3:0] idx_q, idx_d;
  logic full_q, full_d;
  diag_flags_t flags_q, flags_d;
  logic [7:0] shorts_q, shorts_d;
  logic err_q, err_d;
  logic sck_rise;
  logic sck_fall;
  logic transfer_strobe_n_fall;
  logic summary;
  logic [15:0] out_word;
  logic tbl_we;
  logic parity_bad;
  logic clr_diag;
  logic set_err;

  // Edge detection on synchronised pins
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign transfer_strobe_n_fall = ~transfer_strobe_n_s & transfer_strobe_n_prev_q;

  // Summary flag and selected diagnostic word
  assign summary = (|shorts_q) | err_q; // [R23]
  always_comb begin
    if (sel_b_q) begin
      out_word = {summary, flags_q, 2'h0, STEP_ANGLE_NUMBER_I}; // [R08] [R12] [R13]
    end else begin
      out_word = {summary, flags_q, shorts_q}; // [R12] [R13]
    end
  end

  // Next-state logic for transfer, registers and diagnostics
  always_comb begin
    state_d = state_q;
    sck_prev_d = sck_s;
    transfer_strobe_n_prev_d = transfer_strobe_n_s;
    edges_d = edges_q;
    rx_d = rx_q;
    sel_b_d = sel_b_q;
    sdo_d = sdo_q;
    oe_n_d = oe_n_q;
    cfg_a_d = cfg_a_q;
    cfg_b_d = cfg_b_q;
    run_d = run_q;
    idx_d = idx_q;
    full_d = full_q;
    tbl_we = 1'b0;
    parity_bad = 1'b0;
    clr_diag = 1'b0;
    set_err = 1'b0;
    case (state_q)
      XFER_IDLE: begin
        // Nothing shifts while the strobe is high
        oe_n_d = 1'b1; // [R02]
        if (transfer_strobe_n_fall) begin
          state_d = XFER_SHIFT;
          edges_d = 5'h00;
          sel_b_d = 1'b0;
          oe_n_d = 1'b0; // [R09]
          sdo_d = summary; // [R09]
        end
      end
      XFER_SHIFT: begin
        if (transfer_strobe_n_s) begin
          // Strobe rise ends the frame and releases the line
          state_d = XFER_IDLE;
          oe_n_d = 1'b1; // [R11]
          sdo_d = 1'b0;
          if (edges_q == EDGES_PER_WORD) begin
            clr_diag = 1'b1; // [R04]
            case (rx_q[SEL_HI:SEL_LO]) // [R06]
              SEL_CONFIG_A: begin
                cfg_a_d = rx_q[DATA_BITS-1:0]; // [R04]
                idx_d = 4'h0; // [R22]
                full_d = 1'b0;
              end
              SEL_CONFIG_B: begin
                cfg_b_d = rx_q[DATA_BITS-1:0]; // [R04]
                idx_d = 4'h0; // [R22]
                full_d = 1'b0;
              end
              SEL_RUN: begin
                run_d = rx_q[DATA_BITS-1:0]; // [R04]
                idx_d = 4'h0; // [R22]
                full_d = 1'b0;
              end
              SEL_TABLE: begin
                // Sequential profile load, ignored once all sixteen are in
                if (!full_q) begin // [R18]
                  tbl_we = 1'b1; // [R15] [R16]
                  parity_bad = ~(^rx_q[PARITY_POS:0]); // [R21]
                  if (idx_q == TABLE_LAST) begin
                    full_d = 1'b1; // [R18]
                  end else begin
                    idx_d = idx_q + 4'h1; // [R17]
                  end
                end
              end
              default: begin
                clr_diag = 1'b1;
              end
            endcase
          end else if (edges_q != 5'h00) begin
            set_err = 1'b1; // [R05]
            idx_d = 4'h0; // [R22]
            full_d = 1'b0;
          end
          // A frame with no clock edge is a fault poll: no error [R10]
        end else begin
          if (sck_rise) begin
            rx_d = {rx_q[14:0], sdi_s}; // [R01]
            if (edges_q != EDGE_SATURATE) begin
              edges_d = edges_q + 5'h01;
            end
            if (edges_q == 5'h01) begin
              sel_b_d = ({rx_q[0], sdi_s} == SEL_CONFIG_B); // [R08]
            end
          end
          // Next diagnostic bit after each of the first fifteen falling edges
          if (sck_fall && edges_q != 5'h00 && edges_q < EDGES_PER_WORD) begin
            sdo_d = out_word[4'(15 - edges_q)]; // [R07] [R24]
          end
        end
      end
      default: begin
        state_d = XFER_IDLE;
        oe_n_d = 1'b1;
      end
    endcase
  end

  // Sticky diagnostics: new flag and short faults win over any clear
  always_comb begin
    flags_d = flags_q | FAULT_FLAGS_I;
    shorts_d = shorts_q | SHORT_FAULTS_I;
    err_d = err_q;
    if (clr_diag) begin
      flags_d = FAULT_FLAGS_I; // [R04]
      shorts_d = SHORT_FAULTS_I;
      err_d = parity_bad; // [R21]
    end
    if (set_err) begin
      err_d = 1'b1; // [R05]
    end
    if (!rstpin_s) begin
      flags_d = FAULT_FLAGS_I;
      shorts_d = SHORT_FAULTS_I;
      err_d = 1'b0;
    end
  end

  // State registers; power-on gives documented defaults
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= XFER_IDLE;
      sck_prev_q <= 1'b0;
      transfer_strobe_n_prev_q <= 1'b1;
      edges_q <= 5'h00;
      rx_q <= 16'h0000;
      sel_b_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      cfg_a_q <= CONFIG_A_RST; // [R14] [R19]
      cfg_b_q <= CONFIG_B_RST; // [R14]
      run_q <= RUN_RST; // [R14]
      idx_q <= 4'h0; // [R17]
      full_q <= 1'b0;
      flags_q <= FLAGS_RST;
      shorts_q <= SHORTS_RST;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sck_prev_q <= sck_prev_d;
      transfer_strobe_n_prev_q <= transfer_strobe_n_prev_d;
      edges_q <= edges_d;
      rx_q <= rx_d;
      sel_b_q <= sel_b_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
      cfg_a_q <= cfg_a_d;
      cfg_b_q <= cfg_b_d;
      run_q <= run_d;
      idx_q <= rstpin_s ? idx_d : 4'h0; // [R17] [R22]
      full_q <= rstpin_s ? full_d : 1'b0;
      flags_q <= flags_d;
      shorts_q <= shorts_d;
      err_q <= err_d;
    end
  end

  // Profile store; unwritten entries keep their contents
  profile_table_mem #(
    .DEPTH(TABLE_ENTRIES),
    .WIDTH(VALUE_BITS),
    .INIT(PROFILE_RST)
  ) u_profile (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .we_i(tbl_we), // [R16] [R25]
    .waddr_i(idx_q),
    .wdata_i(rx_q[VALUE_BITS-1:0]),
    .raddr_i(STEP_ANGLE_NUMBER_I[3:0]),
    .rdata_o(PROFILE_VALUE_O)
  );

  // Outputs from flip-flops
  assign SDO_O = sdo_q;
  assign SDO_OE_N_O = oe_n_q;
  assign DRIVE_CONFIG_A_O = cfg_a_q;
  assign DRIVE_CONFIG_B_O = cfg_b_q;
  assign MOTION_RUN_CONTROL_O = run_q;

  // Checks
  property p_idle_no_shift;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_IDLE && !transfer_strobe_n_fall) |=> $stable(rx_q);
  endproperty
  a_idle_no_shift: assert property (p_idle_no_shift) else $error("Shift while strobe high"); // [R02]

  property p_sample_in;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && !transfer_strobe_n_s && sck_rise) |=> rx_q[0] == $past(sdi_s) && rx_q[15:1] == $past(rx_q[14:0]);
  endproperty
  a_sample_in: assert property (p_sample_in) else $error("Serial bit not captured"); // [R01]

  property p_commit_run;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && transfer_strobe_n_s && edges_q == EDGES_PER_WORD && rx_q[15:14] == SEL_RUN)
      |=> run_q == $past(rx_q[13:0]) && !oe_n_q == 1'b0;
  endproperty
  a_commit_run: assert property (p_commit_run) else $error("Run word not latched"); // [R04]

  property p_bad_count;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && transfer_strobe_n_s && edges_q != 5'h00 && edges_q != EDGES_PER_WORD)
      |=> err_q && $stable(cfg_a_q) && $stable(cfg_b_q) && $stable(run_q) && idx_q == 4'h0;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("Bad frame not rejected"); // [R05]

  property p_poll;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && transfer_strobe_n_s && edges_q == 5'h00 && !err_q && !set_err) ##0 rstpin_s |=> !err_q;
  endproperty
  a_poll: assert property (p_poll) else $error("Poll raised transfer error"); // [R10]

  property p_drive_on_fall;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_IDLE && transfer_strobe_n_fall) |=> !oe_n_q && sdo_q == $past(summary);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("Summary not driven at strobe fall"); // [R09]

  property p_release;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && transfer_strobe_n_s) |=> oe_n_q ##1 (oe_n_q || state_q == XFER_SHIFT);
  endproperty
  a_release: assert property (p_release) else $error("Output not released"); // [R11]

  property p_table_full;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (full_q && rstpin_s && state_q == XFER_SHIFT && transfer_strobe_n_s && edges_q == EDGES_PER_WORD
      && rx_q[15:14] == SEL_TABLE) |-> !tbl_we ##1 full_q;
  endproperty
  a_table_full: assert property (p_table_full) else $error("Table load accepted after sixteen"); // [R18]

  property p_other_resets_index;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == XFER_SHIFT && transfer_strobe_n_s && edges_q == EDGES_PER_WORD && rx_q[15:14] != SEL_TABLE)
      |=> idx_q == 4'h0 && !full_q;
  endproperty
  a_other_resets_index: assert property (p_other_resets_index) else $error("Index not restarted"); // [R22]

  property p_parity;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (tbl_we && !(^rx_q[6:0]) && rstpin_s) |=> err_q && summary;
  endproperty
  a_parity: assert property (p_parity) else $error("Parity error not flagged"); // [R21]

  property p_index_step;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (tbl_we && rstpin_s && idx_q != TABLE_LAST) |=> idx_q == $past(idx_q) + 4'h1;
  endproperty
  a_index_step: assert property (p_index_step) else $error("Table index did not advance"); // [R17]

endmodule

// ==== serial_master_model.sv ====
// Purpose: Behavioural serial bus master that faces the stepper serial port
// Assumes: Bench clock of 100 MHz; serial clock high for 8 cycles, low for 16 within a frame
// Notes: Serial clock stands still outside frames unless idle_clocks or poll is called
`timescale 1ns/1ps
module serial_master_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic sdi_o,
  output logic transfer_strobe_n_o
);
  // Idle levels at time zero
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    transfer_strobe_n_o = 1'b1;
  end

  // Moves every change just after a rising clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One frame of n bits, MSB first; returns the bits seen on the output line
  task automatic xfer(input int n, input logic [16:0] w, output logic [15:0] rd);
    rd = 16'h0000;
    transfer_strobe_n_o = 1'b0;
    tick(8);
    rd[15] = sdo_i;
    for (int i = 0; i < n; i++) begin
      sdi_o = w[n-1-i];
      tick(8);
      sck_o = 1'b1;
      tick(8);
      sck_o = 1'b0;
      tick(8);
      if (i < 15) begin
        rd[14-i] = sdo_i;
      end
    end
    // Released data line shows the inverse of the last bit
    sdi_o = ~sdi_o;
    transfer_strobe_n_o = 1'b1;
    tick(8);
  endtask

  // Poll with the serial clock held high across the frame
  task automatic poll(output logic flag);
    sck_o = 1'b1;
    tick(8);
    transfer_strobe_n_o = 1'b0;
    tick(8);
    flag = sdo_i;
    transfer_strobe_n_o = 1'b1;
    tick(8);
    sck_o = 1'b0;
    tick(8);
  endtask

  // Serial clock pulses while not selected
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sdi_o = ~sdi_o;
      sck_o = 1'b1;
      tick(8);
      sck_o = 1'b0;
      tick(8);
    end
  endtask
endmodule

// ==== stepper_serial_register_port_tb_top.sv ====
// Purpose: Self-checking bench for the stepper serial register port
// Assumes: Fault inputs held steady so cleared diagnostics reload known values
// Notes: All waits are fixed counts taken from the port latencies
`timescale 1ns/1ps
module stepper_serial_register_port_tb_top;
  import stepper_serial_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  diag_flags_t flags = 7'h2A;
  logic [7:0] shorts = 8'h00;
  logic [5:0] angle = 6'h15;
  logic sck, sdi, strb_n, sdo, sdo_oe_n;
  // Released line shows the inverse, so an undriven read is caught
  wire sdo_w = sdo_oe_n ? ~sdo : sdo;
  logic [13:0] cfg_a, cfg_b, run;
  logic [5:0] prof;
  int bad_count = 0;
  int checked = 0;
  logic [15:0] rd;
  logic f;
  int drive_cycles = 0;
  int n0;

  // Clock source
  always #5 mclk = ~mclk;

  // Counts cycles in which the port drives its output line
  always @(negedge mclk) begin
    if (sdo_oe_n === 1'b0) begin
      drive_cycles++;
    end
  end

  stepper_serial_port i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCK_I(sck), .SDI_I(sdi),
    .TRANSFER_STROBE_N_I(strb_n), .RESET_PIN_N_I(reset_pin_n), .FAULT_FLAGS_I(flags),
    .SHORT_FAULTS_I(shorts), .STEP_ANGLE_NUMBER_I(angle), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n),
    .DRIVE_CONFIG_A_O(cfg_a), .DRIVE_CONFIG_B_O(cfg_b), .MOTION_RUN_CONTROL_O(run),
    .PROFILE_VALUE_O(prof));

  serial_master_model i_master (.clk_i(mclk), .sdo_i(sdo_w), .sck_o(sck), .sdi_o(sdi),
    .transfer_strobe_n_o(strb_n));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Profile entry seen through the step angle read port
  task automatic chk_entry(input logic [5:0] idx, input logic [5:0] exp);
    angle = idx;
    i_master.tick(3);
    chk({10'h000, prof}, {10'h000, exp}, "profile entry");
  endtask

  task automatic t_reset();
    chk({2'b00, cfg_a}, {2'b00, CONFIG_A_RST}, "config a default");
    chk({2'b00, cfg_b}, {2'b00, CONFIG_B_RST}, "config b default");
    chk({2'b00, run}, {2'b00, RUN_RST}, "run default");
    chk({15'h0000, sdo_oe_n}, 16'h0001, "output released");
    chk_entry(6'h00, PROFILE_RST[5:0]);
    angle = 6'h15;
    $display("test reset done");
  endtask

  task automatic t_write();
    n0 = drive_cycles;
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0001, "power-on summary");
    chk(16'(drive_cycles - n0), 16'h0008, "driven only while selected");
    i_master.xfer(16, {1'b0, SEL_CONFIG_A, 14'h1234}, rd);
    chk(rd, 16'hFFFF, "power-on readback");
    chk({2'b00, cfg_a}, 16'h1234, "config a written");
    chk({15'h0000, sdo_oe_n}, 16'h0001, "released after frame");
    i_master.xfer(16, {1'b0, SEL_CONFIG_B, 14'h0555}, rd);
    chk(rd, {1'b0, 7'h2A, 2'b00, 6'h15}, "step angle readback");
    chk({2'b00, cfg_b}, 16'h0555, "config b written");
    i_master.xfer(16, {1'b0, SEL_RUN, 14'h0ABC}, rd);
    chk(rd, {1'b0, 7'h2A, 8'h00}, "short readback");
    chk({2'b00, run}, 16'h0ABC, "run written");
    $display("test write done");
  endtask

  task automatic t_error();
    i_master.xfer(15, {1'b0, 2'b00, 14'h3333} >> 1, rd);
    i_master.xfer(17, {SEL_CONFIG_A, 14'h3333, 1'b1}, rd);
    chk({2'b00, cfg_a}, 16'h1234, "short and long frames discarded");
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0001, "transfer error summary");
    i_master.xfer(16, {1'b0, SEL_CONFIG_A, 14'h0F0F}, rd);
    chk(rd, {1'b1, 7'h2A, 8'h00}, "diagnostics kept");
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0000, "cleared by write");
    shorts = 8'h04;
    i_master.tick(2);
    shorts = 8'h00;
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0001, "short summary");
    reset_pin_n = 1'b0;
    i_master.tick(8);
    reset_pin_n = 1'b1;
    i_master.tick(8);
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0000, "reset pin clears");
    $display("test error done");
  endtask

  task automatic t_idle();
    flags = 7'h6A;
    i_master.tick(2);
    flags = 7'h2A;
    i_master.idle_clocks(8);
    i_master.xfer(16, {1'b0, SEL_RUN, 14'h1111}, rd);
    chk(rd, {1'b0, 7'h6A, 8'h00}, "sticky flag readback");
    chk({2'b00, run}, 16'h1111, "no shift while deselected");
    $display("test idle done");
  endtask

  task automatic t_table();
    logic [5:0] v;
    for (int k = 0; k < 17; k++) begin
      v = (k == 16) ? 6'h3F : 6'(k * 3 + 1);
      i_master.xfer(16, {1'b0, SEL_TABLE, 7'h00, ~^v, v}, rd);
    end
    for (int k = 0; k < 16; k++) begin
      chk_entry(6'(k), 6'(k * 3 + 1));
    end
    i_master.xfer(16, {1'b0, SEL_RUN, 14'h1111}, rd);
    i_master.xfer(16, {1'b0, SEL_TABLE, 7'h00, 1'b1, 6'h2A}, rd);
    i_master.poll(f);
    chk({15'h0000, f}, 16'h0001, "parity error summary");
    i_master.xfer(16, {1'b0, SEL_TABLE, 7'h00, 1'b0, 6'h11}, rd);
    chk_entry(6'h00, 6'h2A);
    chk_entry(6'h01, 6'h11);
    chk_entry(6'h02, 6'h07);
    $display("test table done");
  endtask

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("wrong value at %0t ns: run did not finish", $time);
    results();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    i_master.tick(4);
    t_reset();
    t_write();
    t_error();
    t_idle();
    t_table();
    results();
  end
endmodule
